// *** dv/crb_rom_info_regs_monitor.sv ***
// Checker of the ROM info register bank
`timescale 1ns/100ps
`default_nettype none
module crb_rom_info_regs_monitor
    import crb_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   sys_rst,
    input  wire logic                   soft_rst,
    input  wire crb_pkg::crb_host_req_t host_req,
    input  wire logic [31:0]            host_rdata,
    input  wire logic                   host_rvalid,
    input  wire logic                   eeprom_crc_valid,
    input  wire logic [15:0]            eeprom_crc,
    input  wire crb_pkg::crb_rom_req_t  rom_req,
    input  wire logic [31:0]            rom_rdata,
    input  wire logic                   rom_rvalid,
    input  wire logic                   rom_hit,
    input  wire logic [31:0]            rom_header,
    input  wire logic [31:0]            bus_options
);
    import crb_pkg::*;
    // Short views of the request fields
    wire logic hr = host_req.rd, hw = host_req.wr, rq = rom_req.req;
    wire logic [7:0] ha = host_req.addr;
    wire logic [47:0] ra = rom_req.addr;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    property p_id; hr && ha == CRB_OFS_BUS_IDENT |=> host_rdata == CRB_BUS_IDENT_VAL; endproperty
    a_id: assert property (p_id) else $error("ident read");
    property p_hdr; rq && ra == CRB_BUS_ROM_HDR |=> rom_hit && rom_rdata == $past(rom_header); endproperty
    a_hdr: assert property (p_hdr) else $error("remote header");
    property p_opt; rq && ra == CRB_BUS_OPT |=> rom_rvalid && rom_rdata == $past(bus_options); endproperty
    a_opt: assert property (p_opt) else $error("remote options");
    property p_ro; (bus_options & ~CRB_OPT_WR_MASK) == CRB_OPT_RO_VAL; endproperty
    a_ro: assert property (p_ro) else $error("fixed bits");
    property p_crc; eeprom_crc_valid |=> rom_header[15:0] == $past(eeprom_crc); endproperty
    a_crc: assert property (p_crc) else $error("checksum load");
    property p_hw; hw && ha == CRB_OFS_ROM_HDR && !eeprom_crc_valid && !soft_rst
        |=> rom_header == $past(host_req.wdata); endproperty
    a_hw: assert property (p_hw) else $error("header write");
    property p_cap; hw && ha == CRB_OFS_BUS_OPT && !soft_rst
        |=> bus_options[31:30] == $past(host_req.wdata[31:30]); endproperty
    a_cap: assert property (p_cap) else $error("capability flags");
    property p_mrec; soft_rst |=> $stable(bus_options[15:12]); endproperty
    a_mrec: assert property (p_mrec) else $error("max request kept");
endmodule : crb_rom_info_regs_monitor
bind crb_rom_info_regs crb_rom_info_regs_monitor u_mon (
    .mclk             (mclk),
    .sys_rst          (sys_rst),
    .soft_rst         (soft_rst),
    .host_req         (host_req),
    .host_rdata       (host_rdata),
    .host_rvalid      (host_rvalid),
    .eeprom_crc_valid (eeprom_crc_valid),
    .eeprom_crc       (eeprom_crc),
    .rom_req          (rom_req),
    .rom_rdata        (rom_rdata),
    .rom_rvalid       (rom_rvalid),
    .rom_hit          (rom_hit),
    .rom_header       (rom_header),
    .bus_options      (bus_options)
);
`default_nettype wire

// *** dv/tb_crb_rom_info_regs.sv ***
// Self-checking bench of the ROM info register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module tb_crb_rom_info_regs;
    import crb_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, eeprom_crc_valid = 1'b0;
    logic host_rvalid, rom_rvalid, rom_hit;
    logic [15:0] eeprom_crc = 16'h0000;
    logic [31:0] host_rdata, rom_rdata, rom_header, bus_options, w, exq[$];
    logic [32:0] ex, exr[$];
    crb_host_req_t host_req = '0;
    crb_rom_req_t rom_req = '0;
    int n_errors = 0, n_compared = 0, seed = 68449;
    crb_rom_info_regs DUT (
        .mclk             (mclk),
        .sys_rst          (sys_rst),
        .soft_rst         (soft_rst),
        .host_req         (host_req),
        .host_rdata       (host_rdata),
        .host_rvalid      (host_rvalid),
        .eeprom_crc_valid (eeprom_crc_valid),
        .eeprom_crc       (eeprom_crc),
        .rom_req          (rom_req),
        .rom_rdata        (rom_rdata),
        .rom_rvalid       (rom_rvalid),
        .rom_hit          (rom_hit),
        .rom_header       (rom_header),
        .bus_options      (bus_options)
    );
    initial forever #20 mclk = ~mclk;
    // Bus tasks: drive 1 ns after the edge, reads note the expected answer
    task step; @(posedge mclk); #1; endtask : step
    task wr(input logic [7:0] a, input logic [31:0] d); step; host_req = '{1'b1, 1'b0, a, d}; step;
        host_req = '0; endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e); step;
        host_req = '{1'b0, 1'b1, a, 32'h0000_0000};
        exq.push_back(e); step; host_req = '0; endtask : rd
    task rr(input logic [47:0] a, input logic [32:0] e); step; rom_req = '{1'b1, a};
        exr.push_back(e); step; rom_req = '0; endtask : rr
    // Scoreboard: oldest note against each answer, on settled outputs
    always @(negedge mclk) begin
        if (host_rvalid === 1'b1) begin
            ex = {1'b0, exq.pop_front()};
            `CHK("host", ex[31:0], host_rdata)
        end
        if (rom_rvalid === 1'b1) begin ex = exr.pop_front(); `CHK("rom", ex, {rom_hit, rom_rdata}) end
    end
    // Every noted answer must have arrived before the verdict
    task end_sim; `CHK("pending", 32'h0000_0000, 32'(exq.size() + exr.size()))
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish; endtask : end_sim
    initial begin #50000; n_errors++; end_sim; end
    // Reset values, random write/read-back, remote view, load, soft and hard reset
    initial begin
        repeat (5) @(posedge mclk);
        #1 sys_rst = 1'b0;
        rd(CRB_OFS_ROM_HDR, 32'h0000_0000);
        rd(CRB_OFS_BUS_OPT, 32'h0000_A002);
        rd(8'h24, 32'h0000_0000);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            w = $random(seed);
            wr(CRB_OFS_ROM_HDR, w);
            wr(CRB_OFS_BUS_IDENT, ~w);
            wr(CRB_OFS_BUS_OPT, w);
            rd(CRB_OFS_ROM_HDR, w);
            rd(CRB_OFS_BUS_IDENT, CRB_BUS_IDENT_VAL);
            rd(CRB_OFS_BUS_OPT, w & CRB_OPT_WR_MASK | CRB_OPT_RO_VAL);
            rr(CRB_BUS_ROM_HDR, {1'b1, w});
            rr(CRB_BUS_IDENT, {1'b1, CRB_BUS_IDENT_VAL});
            rr(CRB_BUS_OPT, {1'b1, w & CRB_OPT_WR_MASK | CRB_OPT_RO_VAL});
            rr(48'hFFFF_F000_040C, 33'h0_0000_0000);
        end
        $display("access test done");
        step; eeprom_crc = w[31:16]; eeprom_crc_valid = 1;
        step; eeprom_crc_valid = 0;
        rd(CRB_OFS_ROM_HDR, {w[31:16], w[31:16]});
        step; soft_rst = 1;
        step; soft_rst = 0;
        rd(CRB_OFS_ROM_HDR, 32'h0000_0000);
        rd(CRB_OFS_BUS_OPT, w & 32'h0000_F000 | CRB_OPT_RO_VAL);
        step; sys_rst = 1;
        step; sys_rst = 0;
        rd(CRB_OFS_BUS_OPT, 32'h0000_A002);
        repeat (2) step;
        $display("reset kinds test done");
        end_sim;
    end
endmodule : tb_crb_rom_info_regs
`default_nettype wire

// *** src/crb_pkg.sv ***
// Package with offsets, field layouts and reset values of the ROM info registers
`default_nettype none
package crb_pkg;
    // Host register offsets (byte addresses)
    localparam logic [7:0]  CRB_OFS_ROM_HDR   = 8'h18;
    localparam logic [7:0]  CRB_OFS_BUS_IDENT = 8'h1C;
    localparam logic [7:0]  CRB_OFS_BUS_OPT   = 8'h20;
    // Remote bus addresses of the first three configuration ROM quadlets
    localparam logic [47:0] CRB_BUS_ROM_HDR   = 48'hFFFF_F000_0400;
    localparam logic [47:0] CRB_BUS_IDENT     = 48'hFFFF_F000_0404;
    localparam logic [47:0] CRB_BUS_OPT       = 48'hFFFF_F000_0408;
    // Constant bus identification quadlet, ASCII "1394"
    localparam logic [31:0] CRB_BUS_IDENT_VAL = 32'h3133_3934;
    // ROM header layout and reset
    localparam int          CRB_HDR_CRC_LSB   = 0;
    localparam int          CRB_HDR_CRC_W     = 16;
    localparam logic [31:0] CRB_HDR_RESET     = 32'h0000_0000;
    localparam int          CRB_HDR_UP_LSB    = 16;
    localparam int          CRB_HDR_UP_W      = 16;
    // Bus options layout
    localparam int          CRB_OPT_IRMC_BIT  = 31;
    localparam int          CRB_OPT_CMC_BIT   = 30;
    localparam int          CRB_OPT_MREC_LSB  = 12;
    localparam int          CRB_OPT_MREC_W    = 4;
    localparam int          CRB_OPT_MGMT_LSB  = 27;
    localparam int          CRB_OPT_MGMT_W    = 3;
    localparam int          CRB_OPT_ACC_LSB   = 16;
    localparam int          CRB_OPT_ACC_W     = 8;
    localparam int          CRB_OPT_GEN_LSB   = 6;
    localparam int          CRB_OPT_GEN_W     = 2;
    // Writable bits: 31-27, 23-12, 7-6
    localparam logic [31:0] CRB_OPT_WR_MASK   = 32'hF8FF_F0C0;
    // Fixed read-only content: reserved zeros and link speed 010
    localparam logic [31:0] CRB_OPT_RO_VAL    = 32'h0000_0002;
    // Writable bits reset to zero except max request
    localparam logic [31:0] CRB_OPT_RESET     = 32'h0000_0000;
    // Max request encoding for 2048 bytes: 2^(10+1)
    localparam logic [3:0]  CRB_MREC_2048     = 4'hA;
    // Read data at reset and for unmapped addresses
    localparam logic [31:0] CRB_RDATA_RESET   = 32'h0000_0000;
    localparam logic [31:0] CRB_UNMAPPED_VAL  = 32'h0000_0000;

    // Host register request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } crb_host_req_t;

    // Remote configuration ROM read request
    typedef struct packed {
        logic        req;
        logic [47:0] addr;
    } crb_rom_req_t;
endpackage : crb_pkg
`default_nettype wire

// *** src/crb_rom_info_regs.sv ***
// Host and remote views of the ROM header, bus identification and bus options quadlets
`timescale 1ns/100ps
`default_nettype none
module crb_rom_info_regs
    import crb_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   sys_rst,
    input  wire logic                   soft_rst,
    input  wire crb_pkg::crb_host_req_t host_req,
    output var  logic [31:0]            host_rdata,
    output var  logic                   host_rvalid,
    input  wire logic                   eeprom_crc_valid,
    input  wire logic [15:0]            eeprom_crc,
    input  wire crb_pkg::crb_rom_req_t  rom_req,
    output var  logic [31:0]            rom_rdata,
    output var  logic                   rom_rvalid,
    output var  logic                   rom_hit,
    output var  logic [31:0]            rom_header,
    output var  logic [31:0]            bus_options
);
    import crb_pkg::*;

    // Stored ROM header fields
    logic [CRB_HDR_UP_W-1:0]   hdr_upper_reg;
    logic [CRB_HDR_CRC_W-1:0]  hdr_crc_reg;
    // Stored bus options fields; read-only bits keep no flip-flops
    logic                      irm_cap_reg;
    logic                      cyc_cap_reg;
    logic [CRB_OPT_MGMT_W-1:0] mgmt_cap_reg;
    logic [CRB_OPT_ACC_W-1:0]  clk_acc_reg;
    logic [CRB_OPT_MREC_W-1:0] max_req_reg;
    logic [CRB_OPT_GEN_W-1:0]  gen_reg;
    // Assembled register views
    logic [31:0]               hdr_view;
    logic [31:0]               opt_view;
    // Host and remote decode
    logic                      hdr_wr;
    logic                      opt_wr;
    logic                      hdr_clear;
    logic                      hdr_take;
    logic                      opt_take;
    logic [31:0]               host_next;
    logic [31:0]               rom_next;
    logic                      rom_hit_next;

    // Write strobes for the two writable registers
    assign hdr_wr = host_req.wr && (host_req.addr == CRB_OFS_ROM_HDR);
    assign opt_wr = host_req.wr && (host_req.addr == CRB_OFS_BUS_OPT);

    // Priority: checksum load, then software reset, then host write; the loser is lost
    assign hdr_clear = soft_rst && !eeprom_crc_valid;
    assign hdr_take  = hdr_wr && !soft_rst && !eeprom_crc_valid;
    assign opt_take  = opt_wr && !soft_rst;

    // Info and CRC length fields; frozen in a checksum load cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hdr_upper_reg <= CRB_HDR_RESET[CRB_HDR_UP_LSB +: CRB_HDR_UP_W];
        end else if (hdr_clear) begin
            hdr_upper_reg <= CRB_HDR_RESET[CRB_HDR_UP_LSB +: CRB_HDR_UP_W];
        end else if (hdr_take) begin
            hdr_upper_reg <= host_req.wdata[CRB_HDR_UP_LSB +: CRB_HDR_UP_W];
        end
    end

    // Checksum field; the EEPROM load beats a write or soft reset in the same cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hdr_crc_reg <= CRB_HDR_RESET[CRB_HDR_CRC_LSB +: CRB_HDR_CRC_W];
        end else if (eeprom_crc_valid) begin
            hdr_crc_reg <= eeprom_crc;
        end else if (hdr_clear) begin
            hdr_crc_reg <= CRB_HDR_RESET[CRB_HDR_CRC_LSB +: CRB_HDR_CRC_W];
        end else if (hdr_take) begin
            hdr_crc_reg <= host_req.wdata[CRB_HDR_CRC_LSB +: CRB_HDR_CRC_W];
        end
    end

    // Header view: both stored halves at their bit positions
    always_comb begin
        hdr_view                                   = CRB_HDR_RESET;
        hdr_view[CRB_HDR_UP_LSB +: CRB_HDR_UP_W]   = hdr_upper_reg;
        hdr_view[CRB_HDR_CRC_LSB +: CRB_HDR_CRC_W] = hdr_crc_reg;
    end

    // Resource-manager capable flag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irm_cap_reg <= CRB_OPT_RESET[CRB_OPT_IRMC_BIT];
        end else if (soft_rst) begin
            irm_cap_reg <= CRB_OPT_RESET[CRB_OPT_IRMC_BIT];
        end else if (opt_take) begin
            irm_cap_reg <= host_req.wdata[CRB_OPT_IRMC_BIT];
        end
    end

    // Cycle-master capable flag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cyc_cap_reg <= CRB_OPT_RESET[CRB_OPT_CMC_BIT];
        end else if (soft_rst) begin
            cyc_cap_reg <= CRB_OPT_RESET[CRB_OPT_CMC_BIT];
        end else if (opt_take) begin
            cyc_cap_reg <= host_req.wdata[CRB_OPT_CMC_BIT];
        end
    end

    // Remaining management capability flags, bits 29 to 27
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mgmt_cap_reg <= CRB_OPT_RESET[CRB_OPT_MGMT_LSB +: CRB_OPT_MGMT_W];
        end else if (soft_rst) begin
            mgmt_cap_reg <= CRB_OPT_RESET[CRB_OPT_MGMT_LSB +: CRB_OPT_MGMT_W];
        end else if (opt_take) begin
            mgmt_cap_reg <= host_req.wdata[CRB_OPT_MGMT_LSB +: CRB_OPT_MGMT_W];
        end
    end

    // Cycle master clock accuracy
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_acc_reg <= CRB_OPT_RESET[CRB_OPT_ACC_LSB +: CRB_OPT_ACC_W];
        end else if (soft_rst) begin
            clk_acc_reg <= CRB_OPT_RESET[CRB_OPT_ACC_LSB +: CRB_OPT_ACC_W];
        end else if (opt_take) begin
            clk_acc_reg <= host_req.wdata[CRB_OPT_ACC_LSB +: CRB_OPT_ACC_W];
        end
    end

    // Max request code: hardware reset only, a software reset leaves it alone
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            max_req_reg <= CRB_MREC_2048;
        end else if (opt_take) begin
            max_req_reg <= host_req.wdata[CRB_OPT_MREC_LSB +: CRB_OPT_MREC_W];
        end
    end

    // Generation counter, kept by software
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            gen_reg <= CRB_OPT_RESET[CRB_OPT_GEN_LSB +: CRB_OPT_GEN_W];
        end else if (soft_rst) begin
            gen_reg <= CRB_OPT_RESET[CRB_OPT_GEN_LSB +: CRB_OPT_GEN_W];
        end else if (opt_take) begin
            gen_reg <= host_req.wdata[CRB_OPT_GEN_LSB +: CRB_OPT_GEN_W];
        end
    end

    // Fixed read-only content with the stored fields laid over it
    always_comb begin
        opt_view                                     = CRB_OPT_RO_VAL;
        opt_view[CRB_OPT_IRMC_BIT]                   = irm_cap_reg;
        opt_view[CRB_OPT_CMC_BIT]                    = cyc_cap_reg;
        opt_view[CRB_OPT_MGMT_LSB +: CRB_OPT_MGMT_W] = mgmt_cap_reg;
        opt_view[CRB_OPT_ACC_LSB +: CRB_OPT_ACC_W]   = clk_acc_reg;
        opt_view[CRB_OPT_MREC_LSB +: CRB_OPT_MREC_W] = max_req_reg;
        opt_view[CRB_OPT_GEN_LSB +: CRB_OPT_GEN_W]   = gen_reg;
    end

    // Host read mux; unmapped offsets read zero
    always_comb begin
        unique case (host_req.addr)
            CRB_OFS_ROM_HDR:   host_next = hdr_view;
            CRB_OFS_BUS_IDENT: host_next = CRB_BUS_IDENT_VAL;
            CRB_OFS_BUS_OPT:   host_next = opt_view;
            default:           host_next = CRB_UNMAPPED_VAL;
        endcase
    end

    // Remote ROM read mux at the fixed bus addresses
    always_comb begin
        rom_hit_next = 1'b1;
        unique case (rom_req.addr)
            CRB_BUS_ROM_HDR: rom_next = hdr_view;
            CRB_BUS_IDENT:   rom_next = CRB_BUS_IDENT_VAL;
            CRB_BUS_OPT:     rom_next = opt_view;
            default: begin
                rom_next     = CRB_UNMAPPED_VAL;
                rom_hit_next = 1'b0;
            end
        endcase
    end

    // Host read data registered, valid one cycle after the strobe
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            host_rdata  <= CRB_RDATA_RESET;
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host_req.rd;
            if (host_req.rd) begin
                host_rdata <= host_next;
            end
        end
    end

    // Remote read data registered, valid one cycle after the request
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rom_rdata  <= CRB_RDATA_RESET;
            rom_rvalid <= 1'b0;
            rom_hit    <= 1'b0;
        end else begin
            rom_rvalid <= rom_req.req;
            if (rom_req.req) begin
                rom_rdata <= rom_next;
                rom_hit   <= rom_hit_next;
            end
        end
    end

    // Live copies for the link layer
    assign rom_header  = hdr_view;
    assign bus_options = opt_view;
endmodule : crb_rom_info_regs
`default_nettype wire
